// ==== logic/sioc_params.svh ====
// Register offsets, field layouts, reset values and timing counts for line control
`ifndef SIOC_PARAMS_SVH
`define SIOC_PARAMS_SVH
`define SIOC_NUM_LINES        6
`define SIOC_OFF_LINE_PICK    8'h00
`define SIOC_OFF_LINE_CFG     8'h04
`define SIOC_OFF_SETTLE       8'h08
`define SIOC_OFF_LEVEL        8'h0c
`define SIOC_OFF_SNAPSHOT     8'h10
`define SIOC_CFG_ROLE_LSB     0
`define SIOC_CFG_FLIP_BIT     2
`define SIOC_CFG_DRIVE_BIT    3
`define SIOC_CFG_LEVEL_BIT    4
`define SIOC_CLK_MHZ          250
`define SIOC_SETTLE_RST       16'h000a
`define SIOC_ROLE_RST         2'h1
`endif

// ==== logic/sioc_pkg.sv ====
// Types shared by the line control block
`default_nettype none
package sioc_pkg;
    typedef enum logic [1:0] {
        SIOC_ROLE_QUAD = 2'h0,
        SIOC_ROLE_IN   = 2'h1,
        SIOC_ROLE_OUT  = 2'h2
    } sioc_role_t;
    typedef enum logic {
        SIOC_DRV_OFF  = 1'b0,
        SIOC_DRV_HOST = 1'b1
    } sioc_drive_t;
    typedef enum logic [1:0] {
        SIOC_RD_IDLE,
        SIOC_RD_RESP
    } sioc_rd_state_t;
endpackage
`default_nettype wire

// ==== logic/sioc_line_control.sv ====
// AXI4-Lite controlled six-line I/O block with debounce, inversion and host drive
//
// Overview of operation
// - All per-line settings and level reads act on the line chosen by line_pick.
// - Each line role reads back as quadrature input, general input or output.
// - Level reading returns present logical level of selected line, input or output.
// - With polarity_flip on, the line's logical sense is inverted before use.
// - Input transitions are accepted only after settle_time_us of stability; the code counts shared ticks, so as little as settle_time_us minus one.
// - drive_select picks the output source; off leaves the pin undriven.
// - With host_driven, the pin follows host_drive_level.
// - host_drive_level is active or inactive, asserting or deasserting the line.
// - all_lines_snapshot returns every line's level sampled at the read.
// - Snapshot bits ordered by line number from the first line upward.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sioc_params.svh"
module sioc_line_control (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [5:0]  line_in,
    output logic [5:0]       line_out,
    output logic [5:0]       line_oe
);
    import sioc_pkg::*;

    localparam int NL = `SIOC_NUM_LINES;

    logic [2:0]       line_pick_q;
    sioc_role_t       role_q [NL];
    logic [NL-1:0]    flip_q;
    sioc_drive_t      drive_q [NL];
    logic [NL-1:0]    host_lvl_q;
    logic [15:0]      settle_us_q;
    logic [NL-1:0]    sync1_q;
    logic [NL-1:0]    sync2_q;
    logic [NL-1:0]    deb_q;
    logic [NL-1:0]    logic_lvl;
    logic             aw_hold_q;
    logic             w_hold_q;
    logic [7:0]       awaddr_q;
    logic [31:0]      wdata_q;
    logic [3:0]       wstrb_q;
    sioc_rd_state_t   rd_state_q;

    function automatic logic pick_ok(input logic [2:0] p);
        return p < 3'(NL);
    endfunction

    // Pins are asynchronous: two flops before any logic
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (clk_en) begin
            sync1_q <= line_in;
            sync2_q <= sync1_q;
        end
    end

    // One microsecond tick shared by all debouncers
    logic [7:0] us_cnt_q;
    logic       us_tick;
    assign us_tick = (us_cnt_q == 8'(`SIOC_CLK_MHZ - 1));
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            us_cnt_q <= 8'h00;
        end else if (clk_en) begin
            us_cnt_q <= us_tick ? 8'h00 : us_cnt_q + 8'h01;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NL; g++) begin : g_line
            logic [15:0] cnt_q;
            // Raw change restarts the settle count
            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    cnt_q    <= 16'h0000;
                    deb_q[g] <= 1'b0;
                end else if (clk_en) begin
                    if (sync2_q[g] == deb_q[g]) begin
                        cnt_q <= 16'h0000;
                    end else if (cnt_q >= settle_us_q) begin
                        deb_q[g] <= sync2_q[g];
                        cnt_q    <= 16'h0000;
                    end else if (us_tick) begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
            end
            // Output lines report their driven level, inputs their debounced one
            assign logic_lvl[g] = ((role_q[g] == SIOC_ROLE_OUT) ? host_lvl_q[g] : deb_q[g])
                                  ^ flip_q[g];
            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    line_out[g] <= 1'b0;
                    line_oe[g]  <= 1'b0;
                end else if (clk_en) begin
                    // Off leaves the pin open; level only matters when host driven
                    line_oe[g]  <= (role_q[g] == SIOC_ROLE_OUT)
                                   && (drive_q[g] == SIOC_DRV_HOST);
                    line_out[g] <= host_lvl_q[g] ^ flip_q[g];
                end
            end
        end
    endgenerate

    // Write channel: address and data taken in either order
    logic do_write;
    assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else if (clk_en) begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_hold_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_q == `SIOC_OFF_LINE_PICK
                                 || awaddr_q == `SIOC_OFF_LINE_CFG
                                 || awaddr_q == `SIOC_OFF_SETTLE) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register updates; per-line config lands on the picked line only
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            line_pick_q <= 3'h0;
            settle_us_q <= `SIOC_SETTLE_RST;
            flip_q      <= '0;
            host_lvl_q  <= '0;
            for (int i = 0; i < NL; i++) begin
                role_q[i]  <= sioc_role_t'(`SIOC_ROLE_RST);
                drive_q[i] <= SIOC_DRV_OFF;
            end
        end else if (clk_en && do_write && wstrb_q[0]) begin
            case (awaddr_q)
                `SIOC_OFF_LINE_PICK: begin
                    line_pick_q <= wdata_q[2:0];
                end
                `SIOC_OFF_LINE_CFG: begin
                    if (pick_ok(line_pick_q)) begin
                        if (wdata_q[`SIOC_CFG_ROLE_LSB +: 2] != 2'h3) begin
                            role_q[line_pick_q] <=
                                sioc_role_t'(wdata_q[`SIOC_CFG_ROLE_LSB +: 2]);
                        end
                        flip_q[line_pick_q]     <= wdata_q[`SIOC_CFG_FLIP_BIT];
                        drive_q[line_pick_q]    <=
                            sioc_drive_t'(wdata_q[`SIOC_CFG_DRIVE_BIT]);
                        host_lvl_q[line_pick_q] <= wdata_q[`SIOC_CFG_LEVEL_BIT];
                    end
                end
                `SIOC_OFF_SETTLE: begin
                    if (wstrb_q[1]) begin
                        settle_us_q <= wdata_q[15:0];
                    end else begin
                        settle_us_q <= {settle_us_q[15:8], wdata_q[7:0]};
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Read channel: one beat after the address, data sampled at that edge
    logic [31:0] rd_word;
    logic        rd_ok;
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            `SIOC_OFF_LINE_PICK: rd_word[2:0] = line_pick_q;
            `SIOC_OFF_LINE_CFG: begin
                if (pick_ok(line_pick_q)) begin
                    rd_word[`SIOC_CFG_ROLE_LSB +: 2] = role_q[line_pick_q];
                    rd_word[`SIOC_CFG_FLIP_BIT]      = flip_q[line_pick_q];
                    rd_word[`SIOC_CFG_DRIVE_BIT]     = drive_q[line_pick_q];
                    rd_word[`SIOC_CFG_LEVEL_BIT]     = host_lvl_q[line_pick_q];
                end
            end
            `SIOC_OFF_SETTLE: rd_word[15:0] = settle_us_q;
            `SIOC_OFF_LEVEL: begin
                if (pick_ok(line_pick_q)) begin
                    rd_word[0] = logic_lvl[line_pick_q];
                end
            end
            `SIOC_OFF_SNAPSHOT: rd_word[NL-1:0] = logic_lvl;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rd_state_q    <= SIOC_RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else if (clk_en) begin
            case (rd_state_q)
                SIOC_RD_IDLE: begin
                    s_axi_arready <= !s_axi_arready;
                    if (s_axi_arvalid && s_axi_arready) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid  <= 1'b1;
                        s_axi_rdata   <= rd_word;
                        s_axi_rresp   <= rd_ok ? 2'h0 : 2'h2;
                        rd_state_q    <= SIOC_RD_RESP;
                    end
                end
                SIOC_RD_RESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        rd_state_q   <= SIOC_RD_IDLE;
                    end
                end
                default: rd_state_q <= SIOC_RD_IDLE;
            endcase
        end
    end

    AST_OFF_UNDRIVEN: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && drive_q[4] == SIOC_DRV_OFF |=> !line_oe[4])
        else $error("line 4 driven while drive select is off");
    AST_HOST_LEVEL: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && role_q[4] == SIOC_ROLE_OUT && drive_q[4] == SIOC_DRV_HOST
        |=> line_oe[4] && line_out[4] == ($past(host_lvl_q[4]) ^ $past(flip_q[4])))
        else $error("line 4 pin does not follow host level");
    AST_SNAP_UPPER_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `SIOC_OFF_SNAPSHOT && clk_en
        |=> s_axi_rvalid && s_axi_rdata[31:NL] == '0 && s_axi_rdata[NL-1:0] == $past(logic_lvl))
        else $error("snapshot layout wrong");
    AST_DEB_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && sync2_q[2] != deb_q[2] && g_line[2].cnt_q < settle_us_q |=> $stable(deb_q[2]))
        else $error("debounced level changed before settle time");
    AST_DEB_RESTART: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && sync2_q[3] == deb_q[3] |=> g_line[3].cnt_q == 16'h0000)
        else $error("settle count not restarted");
    AST_LEVEL_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr == `SIOC_OFF_LEVEL
        && pick_ok(line_pick_q) |=> s_axi_rdata[0] == $past(logic_lvl[line_pick_q]))
        else $error("level read mismatch");
    AST_ROLE_VALID: assert property (@(posedge clk_sys) disable iff (!reset_n)
        role_q[0] != sioc_role_t'(2'h3))
        else $error("illegal role code");
    AST_PICK_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && do_write && wstrb_q[0] && awaddr_q == `SIOC_OFF_LINE_CFG
        && line_pick_q == 3'h4
        |=> {flip_q[5], flip_q[3:0]} == $past({flip_q[5], flip_q[3:0]}))
        else $error("config touched unpicked line");
endmodule // sioc_line_control
`default_nettype wire

// ==== verif/sioc_line_partner.sv ====
// Behavioural model of the sensors and actuators wired to the six lines
`timescale 1ns/1ps
`default_nettype none
module sioc_line_partner (
    input  wire logic [5:0] line_out,
    input  wire logic [5:0] line_oe,
    input  wire logic [5:0] sense_lvl,
    output logic      [5:0] line_in
);
    // Driven pin reads back its own level; an open pin shows the sensor
    assign line_in = (line_oe & line_out) | (~line_oe & sense_lvl);
endmodule // sioc_line_partner
`default_nettype wire

// ==== verif/sioc_line_control_tb.sv ====
// Self-checking bench for the six-line I/O control block
`timescale 1ns/1ps
`default_nettype none
`include "sioc_params.svh"
module sioc_line_control_tb;
    import sioc_pkg::*;
    logic        clk_sys, reset_n, clk_en;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [5:0]  line_in, line_out, line_oe, sense_lvl;
    int          miscompares, checks_done;
    int          cycles = 0;

    sioc_line_control u_sioc_line_control (.clk_sys, .reset_n, .clk_en,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .line_in, .line_out, .line_oe);
    sioc_line_partner u_sioc_line_partner (.line_out, .line_oe, .sense_lvl, .line_in);

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            summarize();
        end
    end

    task summarize;
        if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [31:0] cfg(sioc_role_t r, logic f, logic d, logic l);
        return {27'h0, l, d, f, r};
    endfunction

    // Ready is looked at mid-cycle so the taking edge is never raced
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk_sys);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic axi_rd(input logic [7:0] a);
        logic ta, tr;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge clk_sys);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr_pin(input logic [31:0] c, input logic [5:0] oe, input logic [5:0] out);
        axi_wr(`SIOC_OFF_LINE_CFG, c);
        repeat (2) @(negedge clk_sys);
        chk(line_oe, oe, "pin enable");
        chk(line_out & oe, out, "pin level");
        @(posedge clk_sys);
    endtask

    task t_reset;
        axi_rd(`SIOC_OFF_LINE_CFG);
        chk(rd, 32'h00000001, "reset cfg");
        axi_rd(`SIOC_OFF_SETTLE);
        chk(rd, 32'h0000000a, "reset settle");
        axi_rd(8'h20);
        chk({30'h0, resp}, 32'h00000002, "unmapped read");
        axi_wr(`SIOC_OFF_SNAPSHOT, 32'h0000003f);
        chk({30'h0, resp}, 32'h00000002, "read-only write");
        // Short settle keeps the debounce waits cheap
        axi_wr(`SIOC_OFF_SETTLE, 32'h00000002);
    endtask

    task t_roles;
        sioc_role_t roles [3];
        roles = '{SIOC_ROLE_IN, SIOC_ROLE_QUAD, SIOC_ROLE_OUT};
        // Line 0 steps through input, quadrature and output roles in turn
        foreach (roles[i]) begin
            axi_wr(`SIOC_OFF_LINE_CFG, cfg(roles[i], 1'b0, 1'b0, 1'b0));
            axi_rd(`SIOC_OFF_LINE_CFG);
            chk(rd, cfg(roles[i], 1'b0, 1'b0, 1'b0), "role");
        end
        // Reserved role code must leave the output role in place
        axi_wr(`SIOC_OFF_LINE_CFG, 32'h00000003);
        axi_rd(`SIOC_OFF_LINE_CFG);
        chk(rd, cfg(SIOC_ROLE_OUT, 1'b0, 1'b0, 1'b0), "reserved role ignored");
        axi_wr(`SIOC_OFF_LINE_PICK, 32'h00000001);
        axi_rd(`SIOC_OFF_LINE_CFG);
        chk(rd, 32'h00000001, "other line untouched");
    endtask

    task t_snapshot;
        sense_lvl <= 6'h2a;
        repeat (800) @(posedge clk_sys);
        axi_rd(`SIOC_OFF_SNAPSHOT);
        chk(rd, 32'h0000002a, "snapshot");
    endtask

    task t_output;
        axi_wr(`SIOC_OFF_LINE_PICK, 32'h00000004);
        wr_pin(cfg(SIOC_ROLE_OUT, 1'b0, 1'b0, 1'b1), 6'h00, 6'h00);
        wr_pin(cfg(SIOC_ROLE_OUT, 1'b0, 1'b1, 1'b0), 6'h10, 6'h00);
        wr_pin(cfg(SIOC_ROLE_OUT, 1'b0, 1'b1, 1'b1), 6'h10, 6'h10);
        repeat (800) @(posedge clk_sys);
        axi_rd(`SIOC_OFF_LEVEL);
        chk(rd, 32'h00000001, "output level read");
        wr_pin(cfg(SIOC_ROLE_OUT, 1'b1, 1'b1, 1'b1), 6'h10, 6'h00);
        wr_pin(cfg(SIOC_ROLE_OUT, 1'b0, 1'b0, 1'b0), 6'h00, 6'h00);
    endtask

    task t_debounce;
        axi_wr(`SIOC_OFF_LINE_PICK, 32'h00000002);
        // Four ticks: settling takes 754 to 1003 cycles whatever the tick phase
        axi_wr(`SIOC_OFF_SETTLE, 32'h00000004);
        sense_lvl <= 6'h2e;
        repeat (600) @(posedge clk_sys);
        sense_lvl <= 6'h2a;
        repeat (10) @(posedge clk_sys);
        sense_lvl <= 6'h2e;
        // Without a restart the level would already have moved here
        repeat (600) @(posedge clk_sys);
        axi_rd(`SIOC_OFF_LEVEL);
        chk(rd, 32'h00000000, "glitch restarts settle");
        repeat (500) @(posedge clk_sys);
        axi_rd(`SIOC_OFF_LEVEL);
        chk(rd, 32'h00000001, "settled level");
        axi_wr(`SIOC_OFF_LINE_CFG, cfg(SIOC_ROLE_IN, 1'b1, 1'b0, 1'b0));
        repeat (800) @(posedge clk_sys);
        axi_rd(`SIOC_OFF_LEVEL);
        chk(rd, 32'h00000000, "flipped input");
    endtask

    initial begin
        miscompares = 0;
        checks_done = 0;
        clk_en = 1'b1;
        reset_n = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        sense_lvl = 6'h00;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_roles();
        t_snapshot();
        t_output();
        t_debounce();
        summarize();
    end
endmodule // sioc_line_control_tb
`default_nettype wire
